// file: src/sewp_pkg.sv
// Shared constants for the serial EEPROM write and protect controller
// Contract
// RL1: Status write commits on chip select rise after data
// RL2: Status write changes only protect and lock bits
// RL3: Protect and lock bits kept in nonvolatile store
// RL4: Busy flag reports status write; host polls it
// RL5: Status write needs latch set and unlocked pin
// RL6: Status bit 0 reads one while writing
// RL7: Latch clear refuses writes; set allows unprotected
// RL8: Opcode 06h sets the write latch
// RL9: Opcode 04h clears the write latch
// RL10: Latch cleared at reset and write completion
// RL11: Failed or refused writes leave latch unchanged
// RL12: Protect levels none, C000h, 8000h, whole array
// RL13: Lock bit with pin low ignores status writes
// RL14: Pin high leaves status register unprotected
// RL15: Host sends opcode, 16-bit address, then data
// RL16: One to 128 bytes within one page
// RL17: In-page address increments after each byte
// RL18: Over-long page loads keep last 128 bytes
// RL19: Array write starts only on byte boundary
// RL20: Status read shifts bit 7 first, repeating
// RL21: In-page address wraps inside same page
// RL22: MSB first, rising edge sampling, modes 0/3
package sewp_pkg;
    // Opcodes
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_SET_LATCH    = 8'h06;
    // Status field positions
    localparam int BIT_BUSY   = 0;
    localparam int BIT_LATCH  = 1;
    localparam int BIT_BP_LO  = 2;
    localparam int BIT_BP_HI  = 3;
    localparam int BIT_LOCK   = 7;
    // Values after reset
    localparam logic       LATCH_RESET = 1'b0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    // Frame byte counts
    localparam logic [2:0] BYTES_ONE_CMD  = 3'h1;
    localparam logic [2:0] BYTES_STATUS_W = 3'h2;
    localparam logic [2:0] BYTES_WR_MIN   = 3'h4;
    localparam logic [2:0] BYTES_SAT      = 3'h7;
    // Page geometry
    localparam int         PAGE_BYTES = 128;
    localparam logic [7:0] PAGE_END   = 8'h80;
    // Protected region starts (upper address bits)
    localparam logic [1:0] QUARTER_TOP = 2'h3;
    // Data path FIFO shape
    localparam int FIFO_WIDTH = 24;
    localparam int FIFO_DEPTH = 16;
    // Write cycle time
    localparam int CLK_PERIOD_NS = 20;
    localparam int TWC_MS        = 5;
    localparam int TWC_CYCLES    = TWC_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIMER_W       = 18;
    // Frame decoder states
    typedef enum logic [6:0] {
        FS_OPCODE = 7'h01,
        FS_ADDR_HI = 7'h02,
        FS_ADDR_LO = 7'h04,
        FS_DATA   = 7'h08,
        FS_SR_DATA = 7'h10,
        FS_STATUS = 7'h20,
        FS_TAIL   = 7'h40
    } sewp_frame_t;
    // Internal write engine states
    typedef enum logic [2:0] {
        ES_IDLE  = 3'h1,
        ES_DRAIN = 3'h2,
        ES_WAIT  = 3'h4
    } sewp_engine_t;
endpackage

// file: src/sewp_fifo_if.sv
// Handshake bundle between the controller and its data FIFO
`timescale 1ns/1ps
`default_nettype none
interface sewp_fifo_if #(parameter int W = 24);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;
    modport ctrl (output push_valid, output push_data, output pop_ready,
                  input push_ready, input pop_valid, input pop_data);
    modport fifo (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data);
endinterface
`default_nettype wire

// file: src/sewp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sewp_fifo #(
    parameter int W = 24,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    // Both handshake sides
    sewp_fifo_if.fifo io
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic [AW:0]  next_wr_ptr;
    logic [AW:0]  next_rd_ptr;
    logic         full;
    logic         empty;
    logic         do_push;
    logic         do_pop;

    // Extra pointer bit tells full from empty
    always_comb begin
        empty       = (wr_ptr == rd_ptr);
        full        = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
        do_push     = io.push_valid && !full;
        do_pop      = io.pop_ready && !empty;
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    assign io.push_ready = !full;
    assign io.pop_valid  = !empty;
    assign io.pop_data   = mem[rd_ptr[AW-1:0]];

    // Pointer registers
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage, written only on an accepted push
    always_ff @(posedge i_core_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= io.push_data;
        end
    end
endmodule
`default_nettype wire

// file: src/sewp_ctrl.sv
// Serial EEPROM command decoder, write latch, protection and page buffer
`timescale 1ns/1ps
`default_nettype none
module sewp_ctrl #(
    parameter int unsigned P_WRITE_CYCLES = sewp_pkg::TWC_CYCLES
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    // Serial pins, asynchronous to the core clock
    input  wire logic        i_cs_n,
    input  wire logic        i_sck,
    input  wire logic        i_si,
    input  wire logic        i_wp_n,
    output logic             o_so,
    output logic             o_so_oe_n,
    // Nonvolatile status store
    input  wire logic [7:0]  i_nv_restore,
    output logic             o_nv_wr,
    output logic [7:0]       o_nv_bits,
    // Array programming stream
    output logic             o_arr_valid,
    input  wire logic        i_arr_ready,
    output logic [15:0]      o_arr_addr,
    output logic [7:0]       o_arr_data,
    // Visible state
    output logic [7:0]       o_status,
    output logic             o_busy
);
    // Pin synchronisers: cs_n, sck, si, wp_n
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic       sck_prev;
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pin_meta <= 4'b1001;
            pin_sync <= 4'b1001;
            sck_prev <= 1'b0;
        end else begin
            pin_meta <= {i_cs_n, i_sck, i_si, i_wp_n};
            pin_sync <= pin_meta;
            sck_prev <= pin_sync[2];
        end
    end

    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic wp_n_s;
    logic cs_prev;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    assign {cs_n_s, sck_s, si_s, wp_n_s} = pin_sync;
    assign sck_rise = !cs_n_s && sck_s && !sck_prev;   // [RL22]
    assign sck_fall = !cs_n_s && !sck_s && sck_prev;
    assign cs_rise  = cs_n_s && !cs_prev;

    // Frame, status and engine state
    sewp_pkg::sewp_frame_t  fstate, next_fstate;
    sewp_pkg::sewp_engine_t estate, next_estate;
    logic [2:0]   bit_cnt, next_bit_cnt;
    logic [2:0]   byte_cnt, next_byte_cnt;
    logic [7:0]   shift, next_shift;
    logic [7:0]   opcode, next_opcode;
    logic [8:0]   page, next_page;
    logic [6:0]   col, next_col;
    logic [7:0]   sr_data, next_sr_data;
    logic [2:0]   so_idx, next_so_idx;
    logic         so, next_so;
    logic         so_oe_n, next_so_oe_n;
    logic [127:0] mask, next_mask;
    logic         latch, next_latch;
    logic         lock, next_lock;
    logic [1:0]   bp, next_bp;
    logic [2:0]   sr_pend, next_sr_pend;
    logic         is_sr, next_is_sr;
    logic [7:0]   idx, next_idx;
    logic [8:0]   wr_page, next_wr_page;
    logic [sewp_pkg::TIMER_W-1:0] timer, next_timer;
    logic         nv_wr, next_nv_wr;
    logic         buf_we;
    logic [7:0]   page_buf [sewp_pkg::PAGE_BYTES];
    logic [7:0]   byte_val;
    logic         byte_done;
    logic         busy;
    logic         hard_mode;
    logic         page_prot;
    logic         aligned;
    logic [7:0]   status;

    sewp_fifo_if #(.W(sewp_pkg::FIFO_WIDTH)) fifo_bus ();

    assign busy     = (estate != sewp_pkg::ES_IDLE);
    assign byte_val = {shift[6:0], si_s};   // [RL22]
    assign byte_done = sck_rise && (bit_cnt == 3'h7);
    assign aligned  = (bit_cnt == 3'h0);
    // Lock only bites while the pin is low
    assign hard_mode = lock && !wp_n_s;   // [RL13] [RL14]

    // Protected range by level, judged on the page address
    always_comb begin
        case (bp)   // [RL12]
            2'b00:   page_prot = 1'b0;
            2'b01:   page_prot = (page[8:7] == sewp_pkg::QUARTER_TOP);
            2'b10:   page_prot = page[8];
            default: page_prot = 1'b1;
        endcase
    end

    // Status image; reserved bits read zero
    always_comb begin
        status = 8'h00;
        status[sewp_pkg::BIT_BUSY]  = busy;   // [RL6] [RL4]
        status[sewp_pkg::BIT_LATCH] = latch;
        status[sewp_pkg::BIT_BP_LO] = bp[0];
        status[sewp_pkg::BIT_BP_HI] = bp[1];
        status[sewp_pkg::BIT_LOCK]  = lock;
    end

    // Frame decoder next values
    always_comb begin
        next_fstate   = fstate;
        next_bit_cnt  = bit_cnt;
        next_byte_cnt = byte_cnt;
        next_shift    = shift;
        next_opcode   = opcode;
        next_page     = page;
        next_col      = col;
        next_sr_data  = sr_data;
        next_so_idx   = so_idx;
        next_so       = so;
        next_so_oe_n  = so_oe_n;
        next_mask     = mask;
        buf_we        = 1'b0;
        if (cs_n_s) begin
            next_fstate   = sewp_pkg::FS_OPCODE;
            next_bit_cnt  = 3'h0;
            next_byte_cnt = 3'h0;
            next_so_oe_n  = 1'b1;
        end else begin
            if (sck_rise) begin
                next_shift   = byte_val;
                next_bit_cnt = bit_cnt + 3'h1;
            end
            if (byte_done && byte_cnt != sewp_pkg::BYTES_SAT) begin
                next_byte_cnt = byte_cnt + 3'h1;
            end
            case (fstate)
                sewp_pkg::FS_OPCODE: begin
                    if (byte_done) begin
                        next_opcode = byte_val;
                        if (byte_val == sewp_pkg::OP_PAGE_WRITE) begin
                            next_fstate = sewp_pkg::FS_ADDR_HI;
                            if (!busy) begin
                                next_mask = '0;
                            end
                        end else if (byte_val == sewp_pkg::OP_STATUS_WRITE) begin
                            next_fstate = sewp_pkg::FS_SR_DATA;
                        end else if (byte_val == sewp_pkg::OP_STATUS_READ) begin
                            next_fstate = sewp_pkg::FS_STATUS;
                            next_so_idx = 3'h7;
                        end else begin
                            next_fstate = sewp_pkg::FS_TAIL;
                        end
                    end
                end
                sewp_pkg::FS_ADDR_HI: begin
                    if (byte_done) begin   // [RL15]
                        next_page[8:1] = byte_val;
                        next_fstate    = sewp_pkg::FS_ADDR_LO;
                    end
                end
                sewp_pkg::FS_ADDR_LO: begin
                    if (byte_done) begin
                        next_page[0] = byte_val[7];
                        next_col     = byte_val[6:0];
                        next_fstate  = sewp_pkg::FS_DATA;
                    end
                end
                sewp_pkg::FS_DATA: begin
                    if (byte_done && !busy) begin
                        // Later bytes overwrite earlier ones at the same column
                        buf_we          = 1'b1;   // [RL16] [RL18]
                        next_mask[col]  = 1'b1;
                        next_col        = col + 7'h01;   // [RL17] [RL21]
                    end
                end
                sewp_pkg::FS_SR_DATA: begin
                    if (byte_done) begin
                        next_sr_data = byte_val;
                        next_fstate  = sewp_pkg::FS_TAIL;
                    end
                end
                sewp_pkg::FS_STATUS: begin
                    if (sck_fall) begin   // [RL20]
                        next_so      = status[so_idx];
                        next_so_oe_n = 1'b0;
                        next_so_idx  = so_idx - 3'h1;
                    end
                end
                sewp_pkg::FS_TAIL: begin
                    next_fstate = sewp_pkg::FS_TAIL;
                end
                default: begin
                    next_fstate = sewp_pkg::FS_OPCODE;
                end
            endcase
        end
    end

    // Frame decoder registers
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            fstate   <= sewp_pkg::FS_OPCODE;
            bit_cnt  <= 3'h0;
            byte_cnt <= 3'h0;
            shift    <= sewp_pkg::SHIFT_RESET;
            opcode   <= 8'h00;
            page     <= 9'h000;
            col      <= 7'h00;
            sr_data  <= 8'h00;
            so_idx   <= 3'h7;
            so       <= 1'b0;
            so_oe_n  <= 1'b1;
            mask     <= '0;
            cs_prev  <= 1'b1;
        end else begin
            fstate   <= next_fstate;
            bit_cnt  <= next_bit_cnt;
            byte_cnt <= next_byte_cnt;
            shift    <= next_shift;
            opcode   <= next_opcode;
            page     <= next_page;
            col      <= next_col;
            sr_data  <= next_sr_data;
            so_idx   <= next_so_idx;
            so       <= next_so;
            so_oe_n  <= next_so_oe_n;
            mask     <= next_mask;
            cs_prev  <= cs_n_s;
        end
    end

    // Page buffer array
    always_ff @(posedge i_core_clk) begin
        if (buf_we) begin
            page_buf[col] <= byte_val;
        end
    end

    // Command completion at chip select rise, and the write engine
    always_comb begin
        next_estate  = estate;
        next_latch   = latch;
        next_lock    = lock;
        next_bp      = bp;
        next_sr_pend = sr_pend;
        next_is_sr   = is_sr;
        next_idx     = idx;
        next_wr_page = wr_page;
        next_timer   = timer;
        next_nv_wr   = 1'b0;
        fifo_bus.push_valid = 1'b0;
        fifo_bus.push_data  = {wr_page, idx[6:0], page_buf[idx[6:0]]};
        case (estate)
            sewp_pkg::ES_IDLE: begin
                // Busy refuses all but status reads; refused commands keep the latch
                if (cs_rise && aligned) begin   // [RL11] [RL19]
                    if (opcode == sewp_pkg::OP_SET_LATCH && byte_cnt == sewp_pkg::BYTES_ONE_CMD) begin
                        next_latch = 1'b1;   // [RL8]
                    end else if (opcode == sewp_pkg::OP_CLEAR_LATCH
                                 && byte_cnt == sewp_pkg::BYTES_ONE_CMD) begin
                        next_latch = 1'b0;   // [RL9]
                    end else if (opcode == sewp_pkg::OP_STATUS_WRITE
                                 && byte_cnt == sewp_pkg::BYTES_STATUS_W
                                 && latch && !hard_mode) begin   // [RL1] [RL5] [RL13]
                        next_sr_pend = {sr_data[sewp_pkg::BIT_LOCK], sr_data[sewp_pkg::BIT_BP_HI],
                                        sr_data[sewp_pkg::BIT_BP_LO]};   // [RL2]
                        next_is_sr   = 1'b1;
                        next_timer   = sewp_pkg::TIMER_W'(P_WRITE_CYCLES - 1);
                        next_estate  = sewp_pkg::ES_WAIT;
                    end else if (opcode == sewp_pkg::OP_PAGE_WRITE
                                 && byte_cnt >= sewp_pkg::BYTES_WR_MIN
                                 && latch && !page_prot) begin   // [RL7] [RL12]
                        next_is_sr   = 1'b0;
                        next_idx     = 8'h00;
                        next_wr_page = page;
                        next_estate  = sewp_pkg::ES_DRAIN;
                    end
                end
            end
            sewp_pkg::ES_DRAIN: begin
                // Stream only loaded columns; FIFO back-pressure stalls the walk
                if (idx == sewp_pkg::PAGE_END) begin
                    next_timer  = sewp_pkg::TIMER_W'(P_WRITE_CYCLES - 1);
                    next_estate = sewp_pkg::ES_WAIT;
                end else if (!mask[idx[6:0]]) begin
                    next_idx = idx + 8'h01;
                end else begin
                    fifo_bus.push_valid = 1'b1;
                    if (fifo_bus.push_ready) begin
                        next_idx = idx + 8'h01;
                    end
                end
            end
            sewp_pkg::ES_WAIT: begin
                // Write time starts counting once the array has taken every byte
                if (!fifo_bus.pop_valid) begin
                    if (timer == '0) begin
                        next_latch  = 1'b0;   // [RL10]
                        next_estate = sewp_pkg::ES_IDLE;
                        if (is_sr) begin
                            {next_lock, next_bp} = sr_pend;   // [RL3]
                            next_nv_wr = 1'b1;
                        end
                    end else begin
                        next_timer = timer - 1'b1;
                    end
                end
            end
            default: begin
                next_estate = sewp_pkg::ES_IDLE;
            end
        endcase
    end

    // Engine and status registers; nonvolatile bits reload from the store at reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            estate  <= sewp_pkg::ES_IDLE;
            latch   <= sewp_pkg::LATCH_RESET;   // [RL10]
            lock    <= i_nv_restore[sewp_pkg::BIT_LOCK];   // [RL3]
            bp      <= {i_nv_restore[sewp_pkg::BIT_BP_HI], i_nv_restore[sewp_pkg::BIT_BP_LO]};
            sr_pend <= 3'h0;
            is_sr   <= 1'b0;
            idx     <= 8'h00;
            wr_page <= 9'h000;
            timer   <= '0;
            nv_wr   <= 1'b0;
        end else begin
            estate  <= next_estate;
            latch   <= next_latch;
            lock    <= next_lock;
            bp      <= next_bp;
            sr_pend <= next_sr_pend;
            is_sr   <= next_is_sr;
            idx     <= next_idx;
            wr_page <= next_wr_page;
            timer   <= next_timer;
            nv_wr   <= next_nv_wr;
        end
    end

    // Data FIFO toward the array
    sewp_fifo #(
        .W (sewp_pkg::FIFO_WIDTH),
        .D (sewp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .io         (fifo_bus.fifo)
    );

    assign fifo_bus.pop_ready = i_arr_ready;

    // Outputs
    assign o_arr_valid = fifo_bus.pop_valid;
    assign o_arr_addr  = fifo_bus.pop_data[23:8];
    assign o_arr_data  = fifo_bus.pop_data[7:0];
    assign o_so        = so;
    assign o_so_oe_n   = so_oe_n;
    assign o_nv_wr     = nv_wr;
    assign o_nv_bits   = {lock, 3'b000, bp, 2'b00};
    assign o_status    = status;
    assign o_busy      = busy;
endmodule
`default_nettype wire

// file: tb/sewp_monitor.sv
// Port checker for the serial EEPROM controller
`timescale 1ns/1ps
`default_nettype none
module sewp_monitor #(
    parameter int unsigned P_WRITE_CYCLES = 20
) (
    // Clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_reset,
    // Pins and stream inputs
    input wire logic        i_cs_n,
    input wire logic        i_arr_ready,
    // Observed outputs
    input wire logic        o_so_oe_n,
    input wire logic        o_nv_wr,
    input wire logic [7:0]  o_nv_bits,
    input wire logic        o_arr_valid,
    input wire logic [15:0] o_arr_addr,
    input wire logic [7:0]  o_arr_data,
    input wire logic [7:0]  o_status,
    input wire logic        o_busy
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // Busy cycles with an empty FIFO; slack allows for the load gap
    logic [15:0] wait_cnt;
    logic [15:0] next_wait_cnt;
    always_comb begin
        next_wait_cnt = (o_busy && !o_arr_valid) ? wait_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge i_core_clk) begin
        wait_cnt <= i_reset ? 16'h0000 : next_wait_cnt;
    end
    a_busy_mirror: assert property (o_busy == o_status[0])
        else $error("busy differs from status bit 0");
    a_reserved_zero: assert property (o_status[6:4] == 3'h0)
        else $error("reserved status bits set");
    a_nvwr_pulse: assert property (o_nv_wr |=> !o_nv_wr)
        else $error("store pulse too long");
    a_nvbits_shape: assert property (o_nv_wr |-> (o_nv_bits & 8'h73) == 8'h00)
        else $error("stored image holds fixed bits");
    a_latch_end_clear: assert property ($fell(o_busy) |-> !o_status[1])
        else $error("latch kept after write");
    a_latch_set_idle: assert property ($rose(o_status[1]) |-> i_cs_n && !o_busy)
        else $error("latch set mid frame or busy");
    a_protect_frozen: assert property ($changed({o_status[7], o_status[3:2]}) |-> o_nv_wr || $past(o_nv_wr))
        else $error("protect bits moved without commit");
    a_so_released: assert property (i_cs_n [*6] |-> o_so_oe_n)
        else $error("output driven while deselected");
    a_arr_hold: assert property (o_arr_valid && !i_arr_ready |=> o_arr_valid && $stable({o_arr_addr, o_arr_data}))
        else $error("stream byte changed before taken");
    a_write_time: assert property ($fell(o_busy) |-> wait_cnt >= P_WRITE_CYCLES - 1 && wait_cnt <= P_WRITE_CYCLES + 8)
        else $error("write time off");
    c_status_commit: cover property (o_nv_wr);
    c_arr_take: cover property (o_arr_valid && i_arr_ready);
    c_latch_set: cover property ($rose(o_status[1]));
endmodule
bind sewp_ctrl sewp_monitor #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) i_monitor (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_cs_n(i_cs_n), .i_arr_ready(i_arr_ready), .o_so_oe_n(o_so_oe_n),
    .o_nv_wr(o_nv_wr), .o_nv_bits(o_nv_bits), .o_arr_valid(o_arr_valid), .o_arr_addr(o_arr_addr),
    .o_arr_data(o_arr_data), .o_status(o_status), .o_busy(o_busy));
`default_nettype wire

// file: tb/sewp_host_model.sv
// Behavioural serial host framing commands toward the controller
`timescale 1ns/1ps
`default_nettype none
module sewp_host_model (
    // Core clock paces every pin change
    input  wire logic       i_core_clk,
    // Serial pins
    output logic            o_cs_n,
    output logic            o_sck,
    output logic            o_si,
    input  wire logic       i_so,
    // Last eight bits seen
    output logic [7:0]      o_rx
);
    logic idle_hi = 1'b0;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_rx = 8'h00;
    end
    // Shifts n bytes plus extra bits MSB first, mode 0 or 3, clock still outside frames
    task automatic frame(input logic [47:0] d, input int n, input int extra);
        int i;
        o_sck = idle_hi;
        @(negedge i_core_clk);
        o_cs_n = 1'b0;
        repeat (4) @(negedge i_core_clk);
        for (i = 0; i < 8 * n + extra; i++) begin
            o_si = d[47 - i];
            o_sck = 1'b0;
            repeat (4) @(negedge i_core_clk);
            o_sck = 1'b1;
            repeat (4) @(negedge i_core_clk);
            o_rx = {o_rx[6:0], i_so};
        end
        o_sck = idle_hi;
        repeat (4) @(negedge i_core_clk);
        o_cs_n = 1'b1;
        o_si = ~o_si; // Released line shows no stale bit
        repeat (8) @(negedge i_core_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the serial EEPROM controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        i_core_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_wp_n = 1'b1;
    logic        i_arr_ready = 1'b0;
    logic [7:0]  nv_store = 8'h84;
    logic        cs_n, sck, si, so, so_oe_n, nv_wr, arr_valid, busy;
    logic [7:0]  rx, nv_bits, arr_data, status;
    logic [15:0] arr_addr;
    logic [23:0] got[$];
    int          fails = 0;
    int          tests_run = 0;
    always #10 i_core_clk = ~i_core_clk;
    sewp_ctrl #(.P_WRITE_CYCLES(400)) i_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe_n(so_oe_n), .i_nv_restore(nv_store),
        .o_nv_wr(nv_wr), .o_nv_bits(nv_bits), .o_arr_valid(arr_valid), .i_arr_ready(i_arr_ready),
        .o_arr_addr(arr_addr), .o_arr_data(arr_data), .o_status(status), .o_busy(busy));
    sewp_host_model i_host (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so),
        .o_rx(rx));
    // Array side log of every byte taken
    always @(posedge i_core_clk) begin
        if (arr_valid && i_arr_ready) got.push_back({arr_addr, arr_data});
    end
    always @(negedge i_core_clk) if (nv_wr) nv_store <= nv_bits; // Store kept over reset
    task automatic summarize();
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for the internal write to end
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            @(negedge i_core_clk);
            n++;
        end
        if (n == 4000) begin
            fails++;
            summarize();
        end
    endtask
    initial begin
        repeat (2) @(negedge i_core_clk);
        i_reset = 1'b0;
        repeat (4) @(negedge i_core_clk);
        check(status, 32'h0000_0084);
        i_host.frame(48'h0500_0000_0000, 2, 0);
        check(rx, 32'h0000_0084);
        i_host.frame(48'h0200_1055_0000, 4, 0);
        check(busy, 32'h0000_0000);
        i_host.frame(48'h0600_0000_0000, 1, 0);
        check(status, 32'h0000_0086);
        // Locked with pin low: status write ignored
        i_wp_n = 1'b0;
        i_host.frame(48'h0100_0000_0000, 2, 0);
        check(status, 32'h0000_0086);
        // Pin high: write passes, fixed bits dropped
        i_wp_n = 1'b1;
        i_host.frame(48'h01F3_0000_0000, 2, 0);
        check(busy, 32'h0000_0001);
        i_host.frame(48'h0500_0000_0000, 2, 0);
        check(rx, 32'h0000_0087);
        wait_idle();
        check(status, 32'h0000_0080);
        check(nv_bits, 32'h0000_0080);
        i_host.frame(48'h0600_0000_0000, 1, 0);
        i_host.frame(48'h0400_0000_0000, 1, 0);
        check(status, 32'h0000_0080);
        i_host.frame(48'h0100_0000_0000, 2, 0);
        check(status, 32'h0000_0080);
        // Protect the top quarter, then try inside and just below it
        i_host.frame(48'h0600_0000_0000, 1, 0);
        i_host.frame(48'h0104_0000_0000, 2, 0);
        wait_idle();
        i_host.frame(48'h0600_0000_0000, 1, 0);
        i_host.frame(48'h02C0_00AA_0000, 4, 0);
        check(status, 32'h0000_0006);
        i_host.frame(48'h02BF_FEA1_B2C3, 6, 0);
        check(busy, 32'h0000_0001);
        repeat (30) @(negedge i_core_clk);
        i_arr_ready = 1'b1;
        wait_idle();
        check(status, 32'h0000_0004);
        check(got.size(), 32'h0000_0003);
        check(got[0], 32'h00BF_80C3);
        check(got[1], 32'h00BF_FEA1);
        check(got[2], 32'h00BF_FFB2);
        // Refused frames leave the latch
        i_host.frame(48'h0600_0000_0000, 1, 0);
        i_host.frame(48'h0200_1055_0000, 4, 3);
        check(status, 32'h0000_0006);
        i_host.frame(48'h0180_8000_0000, 3, 0);
        check(status, 32'h0000_0006);
        i_host.frame(48'h0300_1000_0000, 4, 0);
        check(status, 32'h0000_0006);
        i_host.idle_hi = 1'b1;
        i_host.frame(48'h0500_0000_0000, 2, 0);
        check(rx, 32'h0000_0006);
        i_reset = 1'b1;
        repeat (2) @(negedge i_core_clk);
        i_reset = 1'b0;
        repeat (4) @(negedge i_core_clk);
        check(status, 32'h0000_0004);
        summarize();
    end
endmodule
`default_nettype wire
